// >>> verilog/coc_top.sv
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "coc_defs.svh"
module coc_top #(
   parameter int NCLK = 8,
   parameter int NREF = 7
) (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire logic [NCLK-1:0]         channel_clock_in,
   output logic      [NCLK-1:0]         channel_clock_out,
   output logic      [NCLK-1:0]         clock_out_on,
   output logic      [2*NCLK-1:0]       clock_out_mv_code,
   output logic      [NCLK-1:0]         clock_out_style,
   output logic      [NREF-1:0]         channel_reference_out,
   output coc_pkg::coc_drv_t [NREF-1:0] reference_drive,
   output logic      [2*NREF-1:0]       reference_mv_code,
   output logic      [NREF-1:0]         reference_style,
   output logic                         oscillator_output,
   input  wire logic                    oscillator_clock_out,
   output logic      [1:0]              oscillator_mv_code,
   output logic                         oscillator_style
);
   import coc_pkg::*;

   // clock outputs A0 A1 B0 B1 C D E0 E1; reference A0 A1 A2 B0 B1 C D
   localparam logic [4*NREF-1:0] REF_CHAN = 28'h3211000;
   localparam logic [4*NCLK-1:0] CLK_CHAN = 32'h44321100;
   // first clock output of each reference's channel: A0 B0 C D
   localparam logic [4*NREF-1:0] REF_CLK  = 28'h5422000;

   logic [4:0]        chan_pd_q;
   logic [NCLK-1:0]   clk_pd_q;
   logic [NCLK+NREF-1:0] en_q;
   logic [NCLK+NREF-1:0] style_q;
   logic [2*NCLK-1:0] clk_amp_q;
   logic [2*NREF-1:0] ref_amp_q;
   logic [NREF-1:0]   ref_sel_q;
   logic [NREF-1:0]   ref_bias_q;
   logic              bias_type_q;
   logic              cont_q;
   logic [7:0]        pulses_q;
   logic              start_q;
   logic [3:0]        osc_q;
   coc_seq_t          seq_q;
   logic [7:0]        cnt_q;
   logic [7:0]        div_q;
   logic              ref_tgl_q;
   logic [1:0]        clk_meta_q [NCLK];
   logic [NCLK-1:0]   clk_s;
   logic [1:0]        osc_meta_q;
   logic              wr_en;
   logic              half_tick;

   function automatic logic [2:0] chan_of(input logic [3:0] c);
      return c[2:0];
   endfunction

   assign wr_en   = psel && penable && pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_pd_q   <= 5'h00;
         clk_pd_q    <= '0;
         en_q        <= '0;
         style_q     <= '0;
         clk_amp_q   <= `COC_RST_AMP;
         ref_amp_q   <= `COC_RST_REF_AMP;
         ref_sel_q   <= '0;
         ref_bias_q  <= '0;
         bias_type_q <= 1'b0;
         cont_q      <= 1'b0;
         pulses_q    <= `COC_RST_PULSES;
         osc_q       <= 4'h0;
      end else if (wr_en) begin
         if (paddr == `COC_OFF_CHAN_PD) begin
            chan_pd_q <= pwdata[4:0];
         end else if (paddr == `COC_OFF_OUT_PD) begin
            clk_pd_q <= pwdata[NCLK-1:0];
         end else if (paddr == `COC_OFF_OUT_EN) begin
            en_q <= pwdata[NCLK+NREF-1:0];
         end else if (paddr == `COC_OFF_OUT_STYLE) begin
            style_q <= pwdata[NCLK+NREF-1:0];
         end else if (paddr == `COC_OFF_OUT_AMP) begin
            clk_amp_q <= pwdata[2*NCLK-1:0];
            ref_amp_q <= pwdata[2*NCLK+2*NREF-1:2*NCLK];
         end else if (paddr == `COC_OFF_REF_SEL) begin
            ref_sel_q <= pwdata[NREF-1:0];
         end else if (paddr == `COC_OFF_REF_BIAS) begin
            ref_bias_q <= pwdata[NREF-1:0];
         end else if (paddr == `COC_OFF_REF_CTRL) begin
            bias_type_q <= pwdata[`COC_CTRL_BIAS_TYPE];
            cont_q      <= pwdata[`COC_CTRL_CONT];
            // zero pulse count is not allowed
            pulses_q    <= (pwdata[`COC_CTRL_CNT_LSB+:8] == 8'h00) ?
                           8'h01 : pwdata[`COC_CTRL_CNT_LSB+:8];
         end else if (paddr == `COC_OFF_OSC) begin
            osc_q <= pwdata[3:0];
         end
      end
   end

   // start is a self-clearing command bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_q <= 1'b0;
      end else begin
         start_q <= wr_en && (paddr == `COC_OFF_REF_CTRL) &&
                    pwdata[`COC_CTRL_START];
      end
   end

   always_comb begin
      prdata = 32'h0000_0000;
      if (paddr == `COC_OFF_CHAN_PD) begin
         prdata[4:0] = chan_pd_q;
      end else if (paddr == `COC_OFF_OUT_PD) begin
         prdata[NCLK-1:0] = clk_pd_q;
      end else if (paddr == `COC_OFF_OUT_EN) begin
         prdata[NCLK+NREF-1:0] = en_q;
      end else if (paddr == `COC_OFF_OUT_STYLE) begin
         prdata[NCLK+NREF-1:0] = style_q;
      end else if (paddr == `COC_OFF_OUT_AMP) begin
         prdata[2*NCLK+2*NREF-1:0] = {ref_amp_q, clk_amp_q};
      end else if (paddr == `COC_OFF_REF_SEL) begin
         prdata[NREF-1:0] = ref_sel_q;
      end else if (paddr == `COC_OFF_REF_BIAS) begin
         prdata[NREF-1:0] = ref_bias_q;
      end else if (paddr == `COC_OFF_REF_CTRL) begin
         prdata[`COC_CTRL_BIAS_TYPE] = bias_type_q;
         prdata[`COC_CTRL_CONT]      = cont_q;
         prdata[`COC_CTRL_CNT_LSB+:8] = pulses_q;
      end else if (paddr == `COC_OFF_STATUS) begin
         prdata[2:0]  = seq_q;
         prdata[15:8] = cnt_q;
      end else if (paddr == `COC_OFF_OSC) begin
         prdata[3:0] = osc_q;
      end
   end

   // reference pulse rate from a pclk divider
   assign half_tick = (div_q == `COC_REF_HALF_DIV - 8'h01);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 8'h00;
      end else if (seq_q != COC_RUN || half_tick) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_q     <= COC_IDLE;
         cnt_q     <= 8'h00;
         ref_tgl_q <= 1'b0;
      end else begin
         case (seq_q)
            COC_IDLE, COC_DONE: begin
               ref_tgl_q <= 1'b0;
               if (start_q) begin
                  seq_q <= COC_RUN;
                  cnt_q <= 8'h00;
               end
            end
            COC_RUN: begin
               if (half_tick) begin
                  ref_tgl_q <= ~ref_tgl_q;
                  if (ref_tgl_q && !cont_q) begin
                     cnt_q <= cnt_q + 8'h01;
                     if (cnt_q + 8'h01 == pulses_q) begin
                        seq_q <= COC_DONE;
                     end
                  end
               end
            end
            default: begin
               seq_q <= COC_IDLE;
            end
         endcase
      end
   end

   for (genvar i = 0; i < NCLK; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            clk_meta_q[i] <= 2'b00;
         end else begin
            clk_meta_q[i] <= {clk_meta_q[i][0], channel_clock_in[i]};
         end
      end
      assign clk_s[i] = clk_meta_q[i][1];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_meta_q <= 2'b00;
      end else begin
         osc_meta_q <= {osc_meta_q[0], oscillator_clock_out};
      end
   end

   // clock outputs, including channel E which has no reference path
   for (genvar i = 0; i < NCLK; i++) begin : g_clk
      logic on;
      assign on = !clk_pd_q[i] &&
                  !chan_pd_q[chan_of(CLK_CHAN[4*i+:4])];
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            channel_clock_out[i] <= 1'b0;
            clock_out_on[i]      <= 1'b0;
            clock_out_mv_code[2*i+:2] <= 2'b00;
            clock_out_style[i]   <= 1'b0;
         end else begin
            clock_out_on[i]      <= on;
            channel_clock_out[i] <= on && en_q[i] && clk_s[i];
            clock_out_mv_code[2*i+:2] <= (on && en_q[i]) ?
                                         clk_amp_q[2*i+:2] : 2'b00;
            clock_out_style[i]   <= style_q[i];
         end
      end
   end

   // reference outputs of channels A to D
   for (genvar r = 0; r < NREF; r++) begin : g_ref
      logic     ch_on;
      logic     en;
      coc_drv_t drv;
      assign ch_on = !chan_pd_q[chan_of(REF_CHAN[4*r+:4])];
      assign en    = en_q[NCLK+r];
      always_comb begin
         drv = COC_DRV_OFF;
         if (!ch_on) begin
            drv = COC_DRV_OFF;
         end else if (ref_sel_q[r]) begin
            if (seq_q == COC_RUN && !(bias_type_q && ref_bias_q[r])) begin
               drv = COC_DRV_RUN;
            end else if (bias_type_q || ref_bias_q[r]) begin
               drv = COC_DRV_MID;
            end else begin
               drv = COC_DRV_LOW;
            end
         end else begin
            drv = en ? COC_DRV_RUN : COC_DRV_LOW;
         end
      end
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            reference_drive[r]       <= COC_DRV_OFF;
            channel_reference_out[r] <= 1'b0;
            reference_mv_code[2*r+:2] <= 2'b00;
            reference_style[r]       <= 1'b0;
         end else begin
            reference_drive[r] <= drv;
            channel_reference_out[r] <= (drv == COC_DRV_RUN) &&
               (ref_sel_q[r] ? ref_tgl_q :
                clk_s[REF_CLK[4*r+:3]]);
            reference_mv_code[2*r+:2] <= (drv == COC_DRV_RUN) ?
                                         ref_amp_q[2*r+:2] : 2'b00;
            reference_style[r] <= style_q[NCLK+r];
         end
      end
   end

   // oscillator output; codes 01 and 10 both give 500 mV
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oscillator_output  <= 1'b0;
         oscillator_mv_code <= 2'b00;
         oscillator_style   <= 1'b0;
      end else begin
         oscillator_output  <= osc_q[`COC_OSC_PWR_ON] && osc_meta_q[1];
         oscillator_mv_code <= osc_q[`COC_OSC_AMP_LSB+:2];
         oscillator_style   <= osc_q[`COC_OSC_STYLE];
      end
   end

   counted_end_a: assert property (@(posedge pclk) disable iff (!presetn)
      seq_q == COC_RUN && half_tick && ref_tgl_q && !cont_q &&
      cnt_q + 8'h01 == pulses_q |=> seq_q == COC_DONE)
      else $error("counted event did not finish");
   start_run_a: assert property (@(posedge pclk) disable iff (!presetn)
      start_q && seq_q != COC_RUN |=> seq_q == COC_RUN)
      else $error("event did not start");
   cont_stay_a: assert property (@(posedge pclk) disable iff (!presetn)
      seq_q == COC_RUN && cont_q |=> seq_q == COC_RUN)
      else $error("continuous mode stopped");
   clk_pd_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_pd_q[0] |=> !clock_out_on[0] && !channel_clock_out[0])
      else $error("powered-down clock output active");
   clk_dis_low_a: assert property (@(posedge pclk) disable iff (!presetn)
      !en_q[1] |=> !channel_clock_out[1])
      else $error("disabled clock output not low");
   ref_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
      ref_sel_q[0] && seq_q != COC_RUN |=>
      reference_drive[0] != COC_DRV_RUN)
      else $error("reference on outside event");
   ref_bias_a: assert property (@(posedge pclk) disable iff (!presetn)
      ref_sel_q[2] && !chan_pd_q[0] && ref_bias_q[2] && seq_q != COC_RUN
      |=> reference_drive[2] == COC_DRV_MID)
      else $error("line bias not at midpoint");
   ref_mid_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      ref_sel_q[3] && !chan_pd_q[1] && bias_type_q && ref_bias_q[3]
      |=> reference_drive[3] == COC_DRV_MID)
      else $error("crosspoint not held");
   ref_low_a: assert property (@(posedge pclk) disable iff (!presetn)
      ref_sel_q[4] && !chan_pd_q[1] && !bias_type_q && !ref_bias_q[4] &&
      seq_q != COC_RUN |=> reference_drive[4] == COC_DRV_LOW)
      else $error("reference not static low");
   osc_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      !osc_q[`COC_OSC_PWR_ON] |=> !oscillator_output)
      else $error("oscillator output not off");

   event_done_c: cover property (@(posedge pclk) disable iff (!presetn)
      seq_q == COC_RUN ##1 seq_q == COC_DONE);
   ref_run_c: cover property (@(posedge pclk) disable iff (!presetn)
      reference_drive[0] == COC_DRV_RUN && ref_sel_q[0]);
   mid_c: cover property (@(posedge pclk) disable iff (!presetn)
      reference_drive[5] == COC_DRV_MID);
endmodule

// >>> verilog/coc_defs.svh
`ifndef COC_DEFS_SVH
`define COC_DEFS_SVH
// apb register offsets
`define COC_OFF_CHAN_PD     12'h000
`define COC_OFF_OUT_PD      12'h004
`define COC_OFF_OUT_EN      12'h008
`define COC_OFF_OUT_STYLE   12'h00c
`define COC_OFF_OUT_AMP     12'h010
`define COC_OFF_REF_SEL     12'h014
`define COC_OFF_REF_BIAS    12'h018
`define COC_OFF_REF_CTRL    12'h01c
`define COC_OFF_STATUS      12'h020
`define COC_OFF_OSC         12'h024
// field positions in reference control
`define COC_CTRL_BIAS_TYPE  0
`define COC_CTRL_CONT       1
`define COC_CTRL_START      2
`define COC_CTRL_CNT_LSB    8
// field positions in oscillator control
`define COC_OSC_PWR_ON      0
`define COC_OSC_STYLE       1
`define COC_OSC_AMP_LSB     2
// reset values
`define COC_RST_PULSES      8'h01
`define COC_RST_AMP         16'h5555
`define COC_RST_REF_AMP     14'h1555
// divider from pclk to reference pulse toggling
`define COC_REF_HALF_DIV    8'h04
`endif

// >>> verilog/coc_pkg.sv
package coc_pkg;
   typedef enum logic [2:0] {
      COC_IDLE = 3'b001,
      COC_RUN  = 3'b010,
      COC_DONE = 3'b100
   } coc_seq_t;
   // driver state: off, static low, toggling, crosspoint bias
   typedef enum logic [1:0] {
      COC_DRV_OFF  = 2'h0,
      COC_DRV_LOW  = 2'h1,
      COC_DRV_RUN  = 2'h2,
      COC_DRV_MID  = 2'h3
   } coc_drv_t;
   typedef logic [1:0] coc_amp_t;
endpackage

// >>> tb/coc_converter.sv
`timescale 1ns/10ps
// converter side: counts rising edges arriving on clock input 3 and reference inputs 0 and 1
module coc_converter (
   input  wire logic       pclk,
   input  wire logic       clr,
   input  wire logic [7:0] clk_in,
   input  wire logic [6:0] ref_in,
   output int              clk_edges,
   output int              ref0_edges,
   output int              ref1_edges
);
   logic [7:0] clk_q;
   logic [6:0] ref_q;
   always_ff @(posedge pclk) begin
      clk_q <= clk_in;
      ref_q <= ref_in;
      if (clr) begin
         clk_edges  <= 0;
         ref0_edges <= 0;
         ref1_edges <= 0;
      end else begin
         clk_edges  <= clk_edges + int'(clk_in[3] & ~clk_q[3]);
         ref0_edges <= ref0_edges + int'(ref_in[0] & ~ref_q[0]);
         ref1_edges <= ref1_edges + int'(ref_in[1] & ~ref_q[1]);
      end
   end
endmodule

// >>> tb/clock_output_channel_control_tb.sv
`timescale 1ns/10ps
`include "coc_defs.svh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module clock_output_channel_control_tb;
   import coc_pkg::*;
   logic             pclk, presetn, psel, penable, pwrite, clr;
   logic [11:0]      paddr;
   logic [31:0]      pwdata, prdata, rd;
   logic             pready, pslverr;
   logic [7:0]       channel_clock_in, channel_clock_out;
   logic [7:0]       clock_out_on, clock_out_style;
   logic [15:0]      clock_out_mv_code;
   logic [6:0]       channel_reference_out, reference_style;
   coc_drv_t [6:0]   reference_drive;
   logic [13:0]      reference_mv_code;
   logic             oscillator_output, oscillator_clock_out;
   logic [1:0]       oscillator_mv_code;
   logic             oscillator_style;
   int               n_tests, fails, ce, r0, r1;
   coc_top i_coc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .channel_clock_in(channel_clock_in),
      .channel_clock_out(channel_clock_out), .clock_out_on(clock_out_on),
      .clock_out_mv_code(clock_out_mv_code),
      .clock_out_style(clock_out_style),
      .channel_reference_out(channel_reference_out),
      .reference_drive(reference_drive),
      .reference_mv_code(reference_mv_code),
      .reference_style(reference_style),
      .oscillator_output(oscillator_output),
      .oscillator_clock_out(oscillator_clock_out),
      .oscillator_mv_code(oscillator_mv_code),
      .oscillator_style(oscillator_style));
   coc_converter i_coc_converter (.pclk(pclk), .clr(clr),
      .clk_in(channel_clock_out), .ref_in(channel_reference_out),
      .clk_edges(ce), .ref0_edges(r0), .ref1_edges(r1));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      channel_clock_in <= ~channel_clock_in;
      oscillator_clock_out <= ~oscillator_clock_out;
   end
   task automatic close_out;
      if (fails == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      repeat (3) @(posedge pclk);
      #1;
   endtask
   task automatic pause(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   task automatic clear;
      @(posedge pclk);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
   endtask
   task automatic wait_seq(input logic [2:0] s);
      for (int i = 0; i < 1000; i++) begin
         apb(1'b0, `COC_OFF_STATUS, 32'h0);
         if (rd[2:0] === s) break;
      end
      pause(2);
   endtask
   task automatic t_reset;
      apb(1'b0, `COC_OFF_STATUS, 32'h0);
      `CHK("seq idle", 3'b001, rd[2:0])
      apb(1'b0, `COC_OFF_OUT_AMP, 32'h0);
      `CHK("amp reset", {2'b00, `COC_RST_REF_AMP, `COC_RST_AMP}, rd)
      apb(1'b0, `COC_OFF_REF_CTRL, 32'h0);
      `CHK("count reset", `COC_RST_PULSES, rd[15:8])
   endtask
   task automatic t_clk;
      wr(`COC_OFF_CHAN_PD, 32'h0);
      wr(`COC_OFF_OUT_PD, 32'h0);
      wr(`COC_OFF_OUT_EN, 32'h7fff);
      wr(`COC_OFF_OUT_STYLE, 32'h41aa);
      wr(`COC_OFF_OUT_AMP, 32'h1555e4e4);
      clear;
      pause(40);
      `CHK("clk on", 8'hff, clock_out_on)
      `CHK("clk mv", 16'he4e4, clock_out_mv_code)
      `CHK("clk style", 8'haa, clock_out_style)
      `CHK("ref style", 7'h41, reference_style)
      `CHK("clk toggles", 1'b1, ce > 10)
      wr(`COC_OFF_OUT_PD, 32'h1);
      wr(`COC_OFF_OUT_EN, 32'h7ffd);
      wr(`COC_OFF_CHAN_PD, 32'h10);
      `CHK("clk on pd", 8'h3e, clock_out_on)
      `CHK("clk mv pd", 16'h04e0, clock_out_mv_code)
      for (int i = 0; i < 8; i++) begin
         pause(1);
         `CHK("clk gated", 8'h00, channel_clock_out & 8'hc3)
      end
      wr(`COC_OFF_CHAN_PD, 32'h0);
      wr(`COC_OFF_OUT_PD, 32'h0);
   endtask
   task automatic t_refclk;
      wr(`COC_OFF_REF_SEL, 32'h0);
      wr(`COC_OFF_OUT_EN, 32'h7eff);
      clear;
      pause(40);
      `CHK("ref0 low", COC_DRV_LOW, reference_drive[0])
      `CHK("ref1 run", COC_DRV_RUN, reference_drive[1])
      `CHK("ref1 clock", 1'b1, r1 > 10)
      `CHK("ref0 quiet", 0, r0)
      for (int i = 0; i < 4; i++) begin
         pause(1);
         `CHK("ref3", ~channel_clock_in[2], channel_reference_out[3])
      end
      wr(`COC_OFF_REF_SEL, 32'h2);
      clear;
      pause(20);
      `CHK("ref1 park", COC_DRV_LOW, reference_drive[1])
      `CHK("ref1 quiet", 0, r1)
      `CHK("ref2 run", COC_DRV_RUN, reference_drive[2])
      wr(`COC_OFF_CHAN_PD, 32'h1);
      `CHK("ref2 off", COC_DRV_OFF, reference_drive[2])
      `CHK("chan a off", 2'b00, clock_out_on[1:0])
      wr(`COC_OFF_CHAN_PD, 32'h0);
   endtask
   task automatic ev(input logic [7:0] cnt, input int n);
      wr(`COC_OFF_REF_CTRL, {16'h0, cnt, 8'h00});
      `CHK("ref before", COC_DRV_LOW, reference_drive[0])
      clear;
      apb(1'b1, `COC_OFF_REF_CTRL, {16'h0, cnt, 8'h04});
      wait_seq(3'b010);
      if (n > 2) begin
         `CHK("ref during", COC_DRV_RUN, reference_drive[0])
         `CHK("ref mv", 14'h1555, reference_mv_code)
      end
      wait_seq(3'b100);
      `CHK("pulses", n, r0)
      `CHK("ref after", COC_DRV_LOW, reference_drive[0])
      apb(1'b0, `COC_OFF_STATUS, 32'h0);
      `CHK("sent", n[7:0], rd[15:8])
   endtask
   task automatic t_event;
      wr(`COC_OFF_REF_SEL, 32'h7f);
      wr(`COC_OFF_REF_BIAS, 32'h0);
      wr(`COC_OFF_OUT_EN, 32'hff);
      ev(8'h03, 3);
      ev(8'h00, 1);
      ev(8'hff, 255);
   endtask
   task automatic t_bias;
      wr(`COC_OFF_REF_BIAS, 32'he);
      wr(`COC_OFF_REF_CTRL, 32'h0301);
      `CHK("ref0 mid", COC_DRV_MID, reference_drive[0])
      `CHK("ref1 mid", COC_DRV_MID, reference_drive[1])
      clear;
      apb(1'b1, `COC_OFF_REF_CTRL, 32'h0305);
      wait_seq(3'b010);
      `CHK("ref0 runs", COC_DRV_RUN, reference_drive[0])
      `CHK("ref1 holds", COC_DRV_MID, reference_drive[1])
      wait_seq(3'b100);
      `CHK("ref1 none", 0, r1)
      `CHK("ref0 three", 3, r0)
      `CHK("ref0 rest", COC_DRV_MID, reference_drive[0])
      wr(`COC_OFF_REF_CTRL, 32'h0300);
      `CHK("line bias", COC_DRV_MID, reference_drive[1])
      `CHK("ref0 static", COC_DRV_LOW, reference_drive[0])
   endtask
   task automatic t_osc;
      int t;
      wr(`COC_OFF_OSC, 32'he);
      for (int i = 0; i < 8; i++) begin
         pause(1);
         `CHK("osc off", 1'b0, oscillator_output)
      end
      `CHK("osc style on", 1'b1, oscillator_style)
      for (int c = 0; c < 4; c++) begin
         wr(`COC_OFF_OSC, {28'h0, c[1:0], 2'b01});
         `CHK("osc mv", c[1:0], oscillator_mv_code)
         `CHK("osc style", 1'b0, oscillator_style)
      end
      t = 0;
      for (int i = 0; i < 10; i++) begin
         pause(1);
         t += int'(oscillator_output !== oscillator_style);
      end
      `CHK("osc runs", 1'b1, t > 2 && t < 9)
   endtask
   task automatic t_unmap;
      apb(1'b1, 12'h030, 32'hffffffff);
      apb(1'b0, 12'h030, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      apb(1'b0, `COC_OFF_OUT_STYLE, 32'h0);
      `CHK("style kept", 32'h41aa, rd)
   endtask
   task automatic t_cont;
      clear;
      apb(1'b1, `COC_OFF_REF_CTRL, 32'h0106);
      pause(120);
      apb(1'b0, `COC_OFF_STATUS, 32'h0);
      `CHK("cont run", 3'b010, rd[2:0])
      `CHK("cont pulses", 1'b1, r0 > 10)
   endtask
   initial begin
      {psel, penable, pwrite, clr} = 4'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      channel_clock_in = 8'h02;
      oscillator_clock_out = 1'b0;
      presetn = 1'b0;
      n_tests = 0;
      fails = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_clk;
      t_refclk;
      t_event;
      t_bias;
      t_osc;
      t_unmap;
      t_cont;
      close_out;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      close_out;
   end
endmodule
